// ---- common/rf_tuning_params.svh ----
// Offsets, field positions, masks and reset values of the RF front-end tuning bank.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef RF_TUNING_PARAMS_SVH
`define RF_TUNING_PARAMS_SVH

// Register byte offsets.
`define SHAPE_ADDR 12'h128
`define TEST_ADDR 12'h1fc
`define PHASE_ADDR 12'h208
`define COARSE_ADDR 12'h120

// Writable bits of each register; all other bits read as zero.
`define SHAPE_MASK 32'h1f02_0fff
`define TEST_MASK 32'h07ff_ffdf
`define PHASE_MASK 32'h0f37_3773
`define COARSE_MASK 32'h0000_007f

// Reset values.
`define SHAPE_RST 32'h0000_0000
`define TEST_RST 32'h0050_000a
`define PHASE_RST 32'h0000_0000
`define COARSE_RST 32'h0000_0000
`define ILOAD_RST 4'ha

// Field positions.
`define RESID_LSB 24
`define BYPASS_BIT 17
`define SLEW_LSB 8
`define FALL_LSB 4
`define RISE_LSB 0
`define ILOAD_LSB 19
`define CREF_BIT 0
`define FSIGN_BIT 27
`define FSTEP_LSB 24
`define COARSE_LSB 0

// Phase arithmetic in 5-degree units: one coarse step is nine fine steps.
`define COARSE_MULT 8'd9
`define PHASE_STEPS 8'd72

// AXI response codes.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- common/rf_tuning_pkg.sv ----
// Types shared by the RF front-end tuning bank.
// Assumes the constants header is included beside it.
`default_nettype none
package rf_tuning_pkg;

	// Transmitter shaping settings as driven to the analog side.
	typedef struct packed {
		logic [4:0] overshoot_residual_level;
		logic shaping_bypass;
		logic [3:0] shunt_slew_setting;
		logic [3:0] fall_edge_time_constant;
		logic [3:0] rise_edge_time_constant;
	} tx_shape_t;

	// Clock phase settings; total is in 5-degree units, 0 to 71.
	typedef struct packed {
		logic [2:0] coarse_phase_step;
		logic fine_phase_sign;
		logic [2:0] fine_phase_step;
		logic [6:0] total_phase;
	} phase_cfg_t;

	// Register selected by an address.
	typedef enum logic [2:0] {SEL_NONE, SEL_SHAPE, SEL_TEST, SEL_PHASE, SEL_COARSE} reg_sel_t;

	// Write channel state.
	typedef enum logic {WR_COLLECT, WR_RESP} wr_state_t;

endpackage
`default_nettype wire

// ---- design/rf_frontend_tuning_regs.sv ----
// Register bank for the RF front-end: transmitter shaping, load and clock phase settings.
// Assumes an AXI4-Lite master on the same clock and static analog consumers of the outputs.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rf_tuning_params.svh"

// Operation
// - Five-bit residual carrier level, bits 28:24.
// - Bit 17 bypasses switched-capacitor shaping.
// - Four-bit shunt regulator slew, bits 11:8.
// - Falling time constant 7:4, only when bypassed.
// - Rising time constant 3:0, only when bypassed.
// - Load current setting 22:19, resets to A.
// - Test bit 0 selects driver-supply carrier reference.
// - Phase bit 27 gives fine offset sign.
// - Fine offset 26:24, 5-degree steps, 0 off.
// - Coarse phase is eight 45-degree steps.
module rf_frontend_tuning_regs #(
	parameter int ADDR_W = 12
) (
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	input wire logic [ADDR_W-1:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [ADDR_W-1:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	output rf_tuning_pkg::tx_shape_t TX_SHAPE_OUT,
	output logic [3:0] ILOAD_OUT,
	output logic CARRIER_REF_OUT,
	output rf_tuning_pkg::phase_cfg_t PHASE_OUT
);
	import rf_tuning_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************

	// The decoder needs the full twelve-bit offset space.
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 12 and 32.");
	end

	// ****************************************
	// Declarations
	// ****************************************

	wr_state_t wr_state_ff, nxt_wr_state; // Write channel state.
	logic aw_have_ff, nxt_aw_have; // Write address held.
	logic w_have_ff, nxt_w_have; // Write data held.
	logic [ADDR_W-1:0] waddr_ff, nxt_waddr; // Held write address.
	logic [31:0] wdata_ff, nxt_wdata; // Held write data.
	logic [3:0] wstrb_ff, nxt_wstrb; // Held byte strobes.
	logic awready_ff, nxt_awready; // Address ready.
	logic wready_ff, nxt_wready; // Data ready.
	logic bvalid_ff, nxt_bvalid; // Response valid.
	logic [1:0] bresp_ff, nxt_bresp; // Response code.
	logic wr_do; // Write is applied in this cycle.
	reg_sel_t wr_sel; // Register targeted by the held write.
	logic arready_ff, nxt_arready; // Read address ready.
	logic rvalid_ff, nxt_rvalid; // Read data valid.
	logic [31:0] rdata_ff, nxt_rdata; // Read data.
	logic [1:0] rresp_ff, nxt_rresp; // Read response code.
	reg_sel_t rd_sel_ff, nxt_rd_sel; // Register of the pending read.
	reg_sel_t ar_sel; // Register addressed on the read channel.
	logic [31:0] shape_ff, nxt_shape; // Shaping control register.
	logic [31:0] test_ff, nxt_test; // Analog test register.
	logic [31:0] phase_ff, nxt_phase; // Phase init register.
	logic [31:0] coarse_ff, nxt_coarse; // Coarse phase register.
	logic [31:0] byte_mask; // Strobes widened to bits.
	tx_shape_t tx_shape_ff, nxt_tx_shape; // Shaping outputs.
	phase_cfg_t phase_out_ff, nxt_phase_out; // Phase outputs.
	logic [3:0] iload_ff, nxt_iload; // Load current output.
	logic cref_ff, nxt_cref; // Carrier reference output.
	logic [7:0] base_ph; // Coarse phase in fine units.
	logic [7:0] fine_ph; // Fine offset in fine units.
	logic [7:0] sum_ph; // Wrapped total phase.

	// ****************************************
	// Address decode
	// ****************************************

	// Maps a byte address to a register; unaligned or unknown addresses give none.
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		if ((a >> 12) == '0) begin
			case (a[11:0])
				`SHAPE_ADDR: s = SEL_SHAPE;
				`TEST_ADDR: s = SEL_TEST;
				`PHASE_ADDR: s = SEL_PHASE;
				`COARSE_ADDR: s = SEL_COARSE;
				default: s = SEL_NONE;
			endcase
		end
		return s;
	endfunction

	assign wr_sel = decode(waddr_ff);
	assign ar_sel = decode(ARADDR_IN);

	// ****************************************
	// Write channel
	// ****************************************

	// The write lands one cycle after both address and data are held.
	assign wr_do = (wr_state_ff == WR_COLLECT) && aw_have_ff && w_have_ff;

	// Address and data are taken in either order and held until the write lands.
	always_comb begin
		nxt_wr_state = wr_state_ff;
		nxt_aw_have = aw_have_ff;
		nxt_w_have = w_have_ff;
		nxt_waddr = waddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		case (wr_state_ff)
			WR_COLLECT: begin
				if (AWVALID_IN && awready_ff) begin
					nxt_aw_have = 1'b1;
					nxt_waddr = AWADDR_IN;
				end
				if (WVALID_IN && wready_ff) begin
					nxt_w_have = 1'b1;
					nxt_wdata = WDATA_IN;
					nxt_wstrb = WSTRB_IN;
				end
				if (wr_do) begin
					// Unknown offsets are answered with an error and change nothing.
					nxt_aw_have = 1'b0;
					nxt_w_have = 1'b0;
					nxt_bvalid = 1'b1;
					nxt_bresp = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
					nxt_wr_state = WR_RESP;
				end
			end
			WR_RESP: begin
				if (BREADY_IN) begin
					nxt_bvalid = 1'b0;
					nxt_wr_state = WR_COLLECT;
				end
			end
			default: begin
				nxt_wr_state = WR_COLLECT;
			end
		endcase
		// Ready only while the slot is free, so one write at most is under way.
		nxt_awready = (nxt_wr_state == WR_COLLECT) && !nxt_aw_have;
		nxt_wready = (nxt_wr_state == WR_COLLECT) && !nxt_w_have;
	end

	// Registers the write channel.
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			wr_state_ff <= WR_COLLECT;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			waddr_ff <= '0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
		end else begin
			wr_state_ff <= nxt_wr_state;
			aw_have_ff <= nxt_aw_have;
			w_have_ff <= nxt_w_have;
			waddr_ff <= nxt_waddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
		end
	end

	// ****************************************
	// Register file
	// ****************************************

	assign byte_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

	// Only writable bits change; reserved read-only bits stay zero.
	always_comb begin
		nxt_shape = shape_ff;
		nxt_test = test_ff;
		nxt_phase = phase_ff;
		nxt_coarse = coarse_ff;
		if (wr_do) begin
			case (wr_sel)
				SEL_SHAPE: begin
					nxt_shape = (shape_ff & ~(byte_mask & `SHAPE_MASK)) | (wdata_ff & byte_mask & `SHAPE_MASK);
				end
				SEL_TEST: begin
					nxt_test = (test_ff & ~(byte_mask & `TEST_MASK)) | (wdata_ff & byte_mask & `TEST_MASK);
				end
				SEL_PHASE: begin
					nxt_phase = (phase_ff & ~(byte_mask & `PHASE_MASK)) | (wdata_ff & byte_mask & `PHASE_MASK);
				end
				SEL_COARSE: begin
					nxt_coarse = (coarse_ff & ~(byte_mask & `COARSE_MASK)) | (wdata_ff & byte_mask & `COARSE_MASK);
				end
				default: begin
					nxt_shape = shape_ff;
				end
			endcase
		end
	end

	// Registers the bank; the load setting comes up at its nonzero default.
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			shape_ff <= `SHAPE_RST;
			test_ff <= `TEST_RST;
			phase_ff <= `PHASE_RST;
			coarse_ff <= `COARSE_RST;
		end else begin
			shape_ff <= nxt_shape;
			test_ff <= nxt_test;
			phase_ff <= nxt_phase;
			coarse_ff <= nxt_coarse;
		end
	end

	// ****************************************
	// Read channel
	// ****************************************

	// A read is answered the cycle after its address is taken; unknown offsets give an error and zero.
	always_comb begin
		nxt_arready = arready_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		nxt_rd_sel = rd_sel_ff;
		if (rvalid_ff) begin
			if (RREADY_IN) begin
				nxt_rvalid = 1'b0;
				nxt_arready = 1'b1;
			end
		end else if (ARVALID_IN && arready_ff) begin
			nxt_arready = 1'b0;
			nxt_rvalid = 1'b1;
			nxt_rd_sel = ar_sel;
			nxt_rresp = `RESP_OKAY;
			case (ar_sel)
				SEL_SHAPE: nxt_rdata = shape_ff;
				SEL_TEST: nxt_rdata = test_ff;
				SEL_PHASE: nxt_rdata = phase_ff;
				SEL_COARSE: nxt_rdata = coarse_ff;
				default: begin
					nxt_rdata = 32'h0000_0000;
					nxt_rresp = `RESP_SLVERR;
				end
			endcase
		end else begin
			nxt_arready = 1'b1;
		end
	end

	// Registers the read channel.
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `RESP_OKAY;
			rd_sel_ff <= SEL_NONE;
		end else begin
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			rd_sel_ff <= nxt_rd_sel;
		end
	end

	// ****************************************
	// Analog settings
	// ****************************************

	// Time constants reach the transmitter only under bypass, else zero.
	// The outputs trail the bank by one cycle, which keeps every output on a flip-flop.
	always_comb begin
		nxt_tx_shape.overshoot_residual_level = shape_ff[`RESID_LSB +: 5];
		nxt_tx_shape.shaping_bypass = shape_ff[`BYPASS_BIT];
		nxt_tx_shape.shunt_slew_setting = shape_ff[`SLEW_LSB +: 4];
		nxt_tx_shape.fall_edge_time_constant = shape_ff[`BYPASS_BIT] ? shape_ff[`FALL_LSB +: 4] : 4'h0;
		nxt_tx_shape.rise_edge_time_constant = shape_ff[`BYPASS_BIT] ? shape_ff[`RISE_LSB +: 4] : 4'h0;
		nxt_iload = test_ff[`ILOAD_LSB +: 4];
		nxt_cref = test_ff[`CREF_BIT];
	end

	// Total phase: coarse times nine, plus or minus the fine code, wrapped at one turn.
	// Codes five to seven are served as written; software is expected to keep clear of them.
	always_comb begin
		base_ph = {5'h00, coarse_ff[`COARSE_LSB +: 3]} * `COARSE_MULT;
		fine_ph = {5'h00, phase_ff[`FSTEP_LSB +: 3]};
		sum_ph = base_ph;
		if (!phase_ff[`FSIGN_BIT]) begin
			sum_ph = base_ph + fine_ph;
			if (sum_ph >= `PHASE_STEPS) begin
				sum_ph = sum_ph - `PHASE_STEPS;
			end
		end else if (base_ph >= fine_ph) begin
			sum_ph = base_ph - fine_ph;
		end else begin
			sum_ph = base_ph + `PHASE_STEPS - fine_ph;
		end
		nxt_phase_out.coarse_phase_step = coarse_ff[`COARSE_LSB +: 3];
		nxt_phase_out.fine_phase_sign = phase_ff[`FSIGN_BIT];
		nxt_phase_out.fine_phase_step = phase_ff[`FSTEP_LSB +: 3];
		nxt_phase_out.total_phase = sum_ph[6:0];
	end

	// Registers the analog outputs.
	always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			tx_shape_ff <= '0;
			phase_out_ff <= '0;
			iload_ff <= `ILOAD_RST;
			cref_ff <= 1'b0;
		end else begin
			tx_shape_ff <= nxt_tx_shape;
			phase_out_ff <= nxt_phase_out;
			iload_ff <= nxt_iload;
			cref_ff <= nxt_cref;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	assign AWREADY_OUT = awready_ff;
	assign WREADY_OUT = wready_ff;
	assign BVALID_OUT = bvalid_ff;
	assign BRESP_OUT = bresp_ff;
	assign ARREADY_OUT = arready_ff;
	assign RVALID_OUT = rvalid_ff;
	assign RDATA_OUT = rdata_ff;
	assign RRESP_OUT = rresp_ff;
	assign TX_SHAPE_OUT = tx_shape_ff;
	assign PHASE_OUT = phase_out_ff;
	assign ILOAD_OUT = iload_ff;
	assign CARRIER_REF_OUT = cref_ff;

	// ****************************************
	// Assertions
	// ****************************************

	a_resid_write: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		wr_do && wr_sel == SEL_SHAPE && wstrb_ff[3]
		|-> ##2 TX_SHAPE_OUT.overshoot_residual_level == $past(wdata_ff[`RESID_LSB +: 5], 2))
		else $error("Residual level did not follow the write.");

	a_bypass_write: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		wr_do && wr_sel == SEL_SHAPE && wstrb_ff[2]
		|-> ##2 TX_SHAPE_OUT.shaping_bypass == $past(wdata_ff[`BYPASS_BIT], 2))
		else $error("Bypass bit did not follow the write.");

	a_slew_write: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		wr_do && wr_sel == SEL_SHAPE && wstrb_ff[1]
		|-> ##2 TX_SHAPE_OUT.shunt_slew_setting == $past(wdata_ff[`SLEW_LSB +: 4], 2))
		else $error("Slew setting did not follow the write.");

	a_fall_gated: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		!TX_SHAPE_OUT.shaping_bypass |-> TX_SHAPE_OUT.fall_edge_time_constant == 4'h0)
		else $error("Falling time constant driven without bypass.");

	a_rise_gated: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		TX_SHAPE_OUT.shaping_bypass |-> TX_SHAPE_OUT.rise_edge_time_constant == $past(shape_ff[`RISE_LSB +: 4]))
		else $error("Rising time constant lost under bypass.");

	a_iload_write: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		wr_do && wr_sel == SEL_TEST && wstrb_ff[2]
		|-> ##2 ILOAD_OUT == $past(wdata_ff[`ILOAD_LSB +: 4], 2))
		else $error("Load setting did not follow the write.");

	a_cref_write: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		wr_do && wr_sel == SEL_TEST && wstrb_ff[0]
		|-> ##2 CARRIER_REF_OUT == $past(wdata_ff[`CREF_BIT], 2))
		else $error("Carrier reference bit did not follow the write.");

	a_fine_off: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		PHASE_OUT.fine_phase_step == 3'h0
		|-> PHASE_OUT.total_phase == 7'({5'h00, PHASE_OUT.coarse_phase_step} * `COARSE_MULT))
		else $error("Fine code zero changed the phase.");

	a_fine_sign: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		PHASE_OUT.fine_phase_sign && PHASE_OUT.coarse_phase_step != 3'h0 && PHASE_OUT.fine_phase_step != 3'h0
		|-> PHASE_OUT.total_phase < 7'({5'h00, PHASE_OUT.coarse_phase_step} * `COARSE_MULT))
		else $error("Negative fine offset did not lower the phase.");

	a_reserved_zero: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
		RVALID_OUT && rd_sel_ff == SEL_SHAPE |-> (RDATA_OUT & ~`SHAPE_MASK) == 32'h0000_0000)
		else $error("Reserved shaping bits read nonzero.");

endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the RF front-end tuning register bank.
// Assumes the design, its package and its constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rf_tuning_params.svh"

// Compares a seen value with an expected one and counts the result.
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, ex, gt); end end

module tb_top;
	import rf_tuning_pkg::*;

	// ************************************************************
	// Signals
	// ************************************************************
	logic clk; // Bench clock, 50 MHz.
	logic nrst; // Active low reset.
	logic [11:0] awaddr, araddr; // Bus addresses.
	logic awvalid, wvalid, bready, arvalid, rready; // Bus handshakes.
	logic [31:0] wdata; // Write data.
	logic [3:0] wstrb; // Byte enables.
	logic awready, wready, bvalid, arready, rvalid; // Slave handshakes.
	logic [1:0] bresp, rresp; // Response codes.
	logic [31:0] rdata; // Read data.
	tx_shape_t tx_shape; // Shaping settings out.
	logic [3:0] iload; // Load current out.
	logic cref; // Carrier reference select out.
	phase_cfg_t phase; // Phase settings out.
	int n_mismatch = 0; // Mismatches seen.
	int checked = 0; // Comparisons made.

	rf_frontend_tuning_regs dut_u (
		.CORE_CLK_IN(clk), .NRST_IN(nrst), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
		.AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
		.WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
		.ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
		.RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .TX_SHAPE_OUT(tx_shape),
		.ILOAD_OUT(iload), .CARRIER_REF_OUT(cref), .PHASE_OUT(phase)
	);

	// Free-running clock.
	always #10 clk = ~clk;

	// ************************************************************
	// Bus tasks
	// ************************************************************

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict;
		$display("Comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One write; address and data offered together, each released when taken.
	// An idle edge at the end keeps the next call from reassigning a handshake in the same step.
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		bit aw_done;
		bit w_done;
		n = 0;
		aw_done = 0;
		w_done = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1;
				wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done) && n < 50);
		do begin
			@(posedge clk);
			n++;
		end while (bvalid !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			$display("Error write handshake expected done seen timeout");
			give_verdict();
		end
		`CHK("bresp", er, bresp)
		bready <= 1'b0;
		@(posedge clk);
	endtask

	// One read; the data and response are taken at the edge where valid is seen.
	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			$display("Error read handshake expected done seen timeout");
			give_verdict();
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	// Reads a register and compares it with the expected word and response.
	task automatic read_chk(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		`CHK("rdata", ex, d)
		`CHK("rresp", er, r)
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************

	// Reset values at the outputs and in the registers.
	task automatic reset_check;
		`CHK("iload", 4'ha, iload)
		`CHK("shape", 18'h0_0000, tx_shape)
		`CHK("cref", 1'b0, cref)
		`CHK("phase", 14'h0000, phase)
		read_chk(`SHAPE_ADDR, 32'h0000_0000, `RESP_OKAY);
		read_chk(`TEST_ADDR, 32'h0050_000a, `RESP_OKAY);
		read_chk(`PHASE_ADDR, 32'h0000_0000, `RESP_OKAY);
		read_chk(`COARSE_ADDR, 32'h0000_0000, `RESP_OKAY);
	endtask

	// Shaping fields, reserved bits, and time constants gated by the bypass bit.
	task automatic shape_check;
		axi_write(`SHAPE_ADDR, 32'hffff_ffff, 4'hf, `RESP_OKAY);
		read_chk(`SHAPE_ADDR, 32'h1f02_0fff, `RESP_OKAY);
		`CHK("shape", 18'h3_ffff, tx_shape)
		axi_write(`SHAPE_ADDR, 32'h1e00_05a3, 4'hf, `RESP_OKAY);
		`CHK("shape", {5'h1e, 1'b0, 4'h5, 4'h0, 4'h0}, tx_shape)
		read_chk(`SHAPE_ADDR, 32'h1e00_05a3, `RESP_OKAY);
		axi_write(`SHAPE_ADDR, 32'h1e02_05a3, 4'hf, `RESP_OKAY);
		`CHK("shape", {5'h1e, 1'b1, 4'h5, 4'ha, 4'h3}, tx_shape)
	endtask

	// Load current and carrier reference, with a single byte lane written first.
	task automatic test_check;
		axi_write(`TEST_ADDR, 32'hffff_ffff, 4'b0100, `RESP_OKAY);
		read_chk(`TEST_ADDR, 32'h00ff_000a, `RESP_OKAY);
		`CHK("iload", 4'hf, iload)
		axi_write(`TEST_ADDR, 32'h0000_0001, 4'hf, `RESP_OKAY);
		`CHK("iload", 4'h0, iload)
		`CHK("cref", 1'b1, cref)
		axi_write(`TEST_ADDR, 32'h0000_0000, 4'hf, `RESP_OKAY);
		`CHK("cref", 1'b0, cref)
	endtask

	// Every fine code with both signs, on the lowest and highest coarse step.
	// Codes five to seven are driven too, since the field must still accept them.
	task automatic phase_check;
		logic [2:0] c;
		logic [2:0] f;
		logic sg;
		int t;
		for (int k = 0; k < 2; k++) begin
			c = (k == 0) ? 3'h0 : 3'h7;
			axi_write(`COARSE_ADDR, {29'h0, c}, 4'hf, `RESP_OKAY);
			for (int i = 0; i < 16; i++) begin
				sg = i[3];
				f = i[2:0];
				t = sg ? (c * 9 + 72 - f) % 72 : (c * 9 + f) % 72;
				axi_write(`PHASE_ADDR, {4'h0, sg, f, 24'h0}, 4'hf, `RESP_OKAY);
				`CHK("phase", {c, sg, f, 7'(t)}, phase)
			end
		end
		axi_write(`PHASE_ADDR, 32'hffff_ffff, 4'hf, `RESP_OKAY);
		read_chk(`PHASE_ADDR, `PHASE_MASK, `RESP_OKAY);
		// The coarse word keeps only its low seven bits; the rest must read zero.
		axi_write(`COARSE_ADDR, 32'hffff_ffff, 4'hf, `RESP_OKAY);
		read_chk(`COARSE_ADDR, `COARSE_MASK, `RESP_OKAY);
	endtask

	// Unmapped and unaligned accesses are refused and change nothing.
	task automatic refuse_check;
		axi_write(12'h100, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
		axi_write(12'h129, 32'h0000_0000, 4'hf, `RESP_SLVERR);
		read_chk(12'h100, 32'h0000_0000, `RESP_SLVERR);
		read_chk(`SHAPE_ADDR, 32'h1e02_05a3, `RESP_OKAY);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		reset_check();
		shape_check();
		test_check();
		phase_check();
		refuse_check();
		give_verdict();
	end

endmodule
`default_nettype wire
